/* fsil_status_top.v */
// fsil_status_top.v: front-panel indicator drive, fieldbus rate detection and slave address holding
// assumes all inputs except arst_n_in are synchronous to clk_sys_in; measurement and fieldbus state come from other logic
`include "fsil_defines.vh"
`default_nettype none

module fsil_status_top #(
  parameter TICK_CYC = `FSIL_TICK_CYC
) (
  input wire clk_sys_in, // 20 MHz system clock
  input wire arst_n_in, // asynchronous reset, active low
  input wire mode_count_in, // 1 = count mode, 0 = weight/force
  input wire meas_stable_in, // measurement stable
  input wire signed [31:0] weight_in, // current weight, signed
  input wire [31:0] division_in, // display division e, same unit as weight
  input wire conv_err_in, // conversion error present
  input wire proc_err_in, // digital processing error present
  input wire [1:0] err_type_in, // error type shown on stable/zero LEDs
  output reg stable_led_out, // stability LED
  output reg zero_led_out, // centre-of-zero LED
  output reg error_led_out, // error LED
  input wire fb_init_done_in, // fieldbus module initialised
  input wire fb_diag_in, // diagnostic event(s) active
  input wire fb_exception_in, // exception error in fieldbus module
  output reg module_state_led_green_out, // module state LED, green
  output reg module_state_led_red_out, // module state LED, red
  input wire fb_online_in, // on-line on the fieldbus
  input wire fb_data_exch_in, // 1 = data exchange, 0 = clear
  input wire fb_cfg_err_in, // configuration error
  output reg link_operation_led_green_out, // operation LED, green
  output reg link_operation_led_red_out, // operation LED, red
  input wire fb_rx_in, // fieldbus receive line
  input wire fb_rate_restart_in, // pulse: forget detected rate
  output reg [3:0] fb_rate_out, // detected rate index
  output reg fb_rate_lock_out, // a rate has been detected
  input wire [6:0] addr_switch_in, // address from setup switch
  input wire addr_switch_load_in, // pulse: take switch address
  input wire [6:0] addr_cfg_in, // address from configuration
  input wire addr_cfg_load_in, // pulse: take configuration address
  output reg [6:0] slave_addr_out, // active slave address
  output reg addr_reject_out, // pulse: out-of-range address refused
  input wire [7:0] aux_tx_data_in, // aux serial byte to send
  input wire aux_tx_valid_in, // aux byte offered
  output wire aux_tx_ready_out, // aux transmitter idle
  output wire aux_tx_out, // aux serial line out
  input wire aux_rx_in, // aux serial line in
  output wire [7:0] aux_rx_data_out, // aux byte received
  output wire aux_rx_valid_out, // pulse: aux byte good
  output wire aux_rx_frame_err_out // pulse: aux stop bit bad
);

////////////////////////////////////////////////////////////////////////////////
reg [1:0] rst_sync_r;
wire rst_n;

always @(posedge clk_sys_in or negedge arst_n_in) begin
  if (!arst_n_in) begin
    rst_sync_r <= 2'b00;
  end else begin
    rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
end

assign rst_n = rst_sync_r[1];

////////////////////////////////////////////////////////////////////////////////
// millisecond timebase and 2 s pattern counter shared by every blinking LED
reg [15:0] tick_cnt_r;
reg tick_r;
reg [10:0] ms_cnt_r;

always @(posedge clk_sys_in or negedge rst_n) begin
  if (!rst_n) begin
    tick_cnt_r <= 16'h0000;
    tick_r <= 1'b0;
  end else if (tick_cnt_r == TICK_CYC - 1) begin
    tick_cnt_r <= 16'h0000;
    tick_r <= 1'b1;
  end else begin
    tick_cnt_r <= tick_cnt_r + 16'h0001;
    tick_r <= 1'b0;
  end
end

always @(posedge clk_sys_in or negedge rst_n) begin
  if (!rst_n) begin
    ms_cnt_r <= 11'h000;
  end else if (tick_r) begin
    if (ms_cnt_r == `FSIL_CNT_PERIOD_MS - 1) begin
      ms_cnt_r <= 11'h000;
    end else begin
      ms_cnt_r <= ms_cnt_r + 11'h001;
    end
  end
end

wire count_dark = (ms_cnt_r < `FSIL_CNT_OFF_MS); // see [RULE_01]
wire flash_on = (ms_cnt_r < `FSIL_FLASH_HALF_MS) ||
                ((ms_cnt_r >= 2 * `FSIL_FLASH_HALF_MS) && (ms_cnt_r < 3 * `FSIL_FLASH_HALF_MS));
// two short red pulses then a long pause, so the double flash is told apart from plain flashing
wire red_double = (ms_cnt_r < `FSIL_RED_PULSE_MS) ||
                  ((ms_cnt_r >= 2 * `FSIL_RED_PULSE_MS) && (ms_cnt_r < 3 * `FSIL_RED_PULSE_MS));

////////////////////////////////////////////////////////////////////////////////
// centre of zero: |w| < 0.25 e is tested as 4|w| < e, so no fraction is needed
wire [31:0] weight_abs = weight_in[31] ? (~weight_in + 32'h00000001) : weight_in;
wire [33:0] weight_x4 = {weight_abs, 2'b00};
wire in_zero = (weight_x4 < {2'b00, division_in}); // see [RULE_02]
wire any_err = conv_err_in | proc_err_in;

always @(posedge clk_sys_in or negedge rst_n) begin
  if (!rst_n) begin
    stable_led_out <= 1'b0;
    zero_led_out <= 1'b0;
    error_led_out <= 1'b0;
  end else begin
    error_led_out <= any_err; // see [RULE_05]
    if (any_err) begin
      stable_led_out <= err_type_in[0]; // see [RULE_06]
      zero_led_out <= err_type_in[1]; // see [RULE_06]
    end else if (mode_count_in) begin
      stable_led_out <= ~count_dark; // see [RULE_01]
      zero_led_out <= 1'b0; // see [RULE_03]
    end else begin
      stable_led_out <= meas_stable_in; // see [RULE_04]
      zero_led_out <= in_zero; // see [RULE_02]
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// exception outranks diagnostics; uninitialised outranks both
always @(posedge clk_sys_in or negedge rst_n) begin
  if (!rst_n) begin
    module_state_led_green_out <= 1'b0;
    module_state_led_red_out <= 1'b0;
  end else if (!fb_init_done_in) begin
    module_state_led_green_out <= 1'b0; // see [RULE_07]
    module_state_led_red_out <= 1'b0; // see [RULE_07]
  end else if (fb_exception_in) begin
    module_state_led_green_out <= 1'b0;
    module_state_led_red_out <= 1'b1; // see [RULE_09]
  end else begin
    module_state_led_green_out <= fb_diag_in ? flash_on : 1'b1; // see [RULE_08]
    module_state_led_red_out <= 1'b0;
  end
end

always @(posedge clk_sys_in or negedge rst_n) begin
  if (!rst_n) begin
    link_operation_led_green_out <= 1'b0;
    link_operation_led_red_out <= 1'b0;
  end else if (fb_cfg_err_in) begin
    link_operation_led_green_out <= 1'b0;
    link_operation_led_red_out <= red_double; // see [RULE_10]
  end else if (!fb_online_in) begin
    link_operation_led_green_out <= 1'b0; // see [RULE_10]
    link_operation_led_red_out <= 1'b0;
  end else begin
    link_operation_led_green_out <= fb_data_exch_in ? 1'b1 : flash_on; // see [RULE_10]
    link_operation_led_red_out <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// rate detection: the shortest low or high run on the line is one bit time
// limitation: at 20 MHz the three fastest rates are told apart only by 1 to 3 clocks
function [3:0] rate_of;
  input [11:0] width;
  begin
    if (width >= `FSIL_THR_9K6) rate_of = `FSIL_RATE_9K6;
    else if (width >= `FSIL_THR_19K2) rate_of = `FSIL_RATE_19K2;
    else if (width >= `FSIL_THR_45K45) rate_of = `FSIL_RATE_45K45;
    else if (width >= `FSIL_THR_93K75) rate_of = `FSIL_RATE_93K75;
    else if (width >= `FSIL_THR_187K5) rate_of = `FSIL_RATE_187K5;
    else if (width >= `FSIL_THR_500K) rate_of = `FSIL_RATE_500K;
    else if (width >= `FSIL_THR_1M5) rate_of = `FSIL_RATE_1M5;
    else if (width >= `FSIL_THR_3M) rate_of = `FSIL_RATE_3M;
    else if (width >= `FSIL_THR_6M) rate_of = `FSIL_RATE_6M;
    else rate_of = `FSIL_RATE_12M;
  end
endfunction

reg fb_prev_r;
reg [11:0] run_cnt_r;
reg [11:0] run_min_r;
reg run_seen_r;
wire fb_edge = fb_prev_r ^ fb_rx_in;

always @(posedge clk_sys_in or negedge rst_n) begin
  if (!rst_n) begin
    fb_prev_r <= 1'b1;
    run_cnt_r <= 12'h000;
    run_min_r <= 12'hFFF;
    run_seen_r <= 1'b0;
    fb_rate_out <= `FSIL_RATE_NONE;
    fb_rate_lock_out <= 1'b0;
  end else begin
    fb_prev_r <= fb_rx_in;
    if (fb_rate_restart_in) begin
      run_cnt_r <= 12'h000;
      run_min_r <= 12'hFFF;
      run_seen_r <= 1'b0;
      fb_rate_out <= `FSIL_RATE_NONE;
      fb_rate_lock_out <= 1'b0;
    end else if (fb_edge) begin
      run_cnt_r <= 12'h001;
      run_seen_r <= 1'b1;
      // the first run after restart may be cut short by the restart itself
      if (run_seen_r && (run_cnt_r < run_min_r)) begin
        run_min_r <= run_cnt_r;
        fb_rate_out <= rate_of(run_cnt_r); // see [RULE_12]
        fb_rate_lock_out <= 1'b1;
      end
    end else if (run_cnt_r != 12'hFFF) begin
      run_cnt_r <= run_cnt_r + 12'h001;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
function addr_ok;
  input [6:0] addr;
  begin
    addr_ok = (addr >= `FSIL_ADDR_MIN) && (addr <= `FSIL_ADDR_MAX);
  end
endfunction

// the switch wins when both sources load in the same cycle: it is the local operator's choice
always @(posedge clk_sys_in or negedge rst_n) begin
  if (!rst_n) begin
    slave_addr_out <= `FSIL_ADDR_RST; // see [RULE_13]
    addr_reject_out <= 1'b0;
  end else begin
    addr_reject_out <= 1'b0;
    if (addr_switch_load_in) begin
      if (addr_ok(addr_switch_in)) begin
        slave_addr_out <= addr_switch_in; // see [RULE_14]
      end else begin
        addr_reject_out <= 1'b1; // see [RULE_13]
      end
    end else if (addr_cfg_load_in) begin
      if (addr_ok(addr_cfg_in)) begin
        slave_addr_out <= addr_cfg_in; // see [RULE_13]
      end else begin
        addr_reject_out <= 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
fsil_uart #(
  .BIT_CYC(`FSIL_UART_BIT_CYC)
) u_aux_uart (
  .clk_in(clk_sys_in),
  .rst_n_in(rst_n),
  .tx_data_in(aux_tx_data_in),
  .tx_valid_in(aux_tx_valid_in),
  .tx_ready_out(aux_tx_ready_out),
  .tx_out(aux_tx_out),
  .rx_in(aux_rx_in),
  .rx_data_out(aux_rx_data_out),
  .rx_valid_out(aux_rx_valid_out),
  .rx_frame_err_out(aux_rx_frame_err_out)
);

endmodule
`default_nettype wire

/* fsil_defines.vh */
// fsil_defines.vh: timing, pattern and range constants for the status indicator logic
// assumes a single 20 MHz system clock; included by every design file of the block
//
// Functional notes
// [RULE_01] count mode: stable LED dark 0.3 s in every 2 s period, no real stability shown
// [RULE_02] weight/force mode: zero LED lit only while -0.25 e < weight < +0.25 e
// [RULE_03] count mode: zero LED always dark
// [RULE_04] weight/force mode: stable LED lit while stable, dark while unstable
// [RULE_05] error LED lit on conversion or processing error, any mode, else dark
// [RULE_06] while error LED lit, stable and zero LEDs carry the error type
// [RULE_07] module state LED dark while unpowered or fieldbus module initialising
// [RULE_08] module state LED steady green when initialised, flashing green with diagnostics
// [RULE_09] module state LED red whenever an exception error exists; here only once fb_init_done_in is set, dark before
// [RULE_10] operation LED: off offline, green exchange, flash green clear, red double flash config error
// [RULE_11] auxiliary serial port runs 9600 bit/s, 1 start, 8 data, no parity, 1 stop
// [RULE_12] fieldbus bit rate detected automatically among ten rates, no rate setting
// [RULE_13] slave address accepted from 1 to 126, default 1
// [RULE_14] slave address may also be loaded from the front-panel setup switch
`ifndef FSIL_DEFINES_VH
`define FSIL_DEFINES_VH

`define FSIL_CLK_HZ 20000000
// indicator timebase: one tick per millisecond
`define FSIL_TICK_US 1000
`define FSIL_TICK_CYC ((`FSIL_CLK_HZ / 1000000) * `FSIL_TICK_US)
// pattern figures in milliseconds
`define FSIL_CNT_PERIOD_MS 2000
`define FSIL_CNT_OFF_MS 300
`define FSIL_FLASH_HALF_MS 500
`define FSIL_RED_PULSE_MS 200
// auxiliary serial framing
`define FSIL_UART_BAUD 9600
`define FSIL_UART_BIT_CYC (`FSIL_CLK_HZ / `FSIL_UART_BAUD)
`define FSIL_UART_DATA_BITS 8
// slave address range
`define FSIL_ADDR_MIN 7'h01
`define FSIL_ADDR_MAX 7'h7E
`define FSIL_ADDR_RST 7'h01
// fieldbus rate indices, slowest first
`define FSIL_RATE_NONE 4'hF
`define FSIL_RATE_9K6 4'h0
`define FSIL_RATE_19K2 4'h1
`define FSIL_RATE_45K45 4'h2
`define FSIL_RATE_93K75 4'h3
`define FSIL_RATE_187K5 4'h4
`define FSIL_RATE_500K 4'h5
`define FSIL_RATE_1M5 4'h6
`define FSIL_RATE_3M 4'h7
`define FSIL_RATE_6M 4'h8
`define FSIL_RATE_12M 4'h9
// shortest-pulse thresholds in clocks, geometric means of adjacent bit times
`define FSIL_THR_9K6 12'd1472
`define FSIL_THR_19K2 12'd677
`define FSIL_THR_45K45 12'd306
`define FSIL_THR_93K75 12'd150
`define FSIL_THR_187K5 12'd65
`define FSIL_THR_500K 12'd23
`define FSIL_THR_1M5 12'd9
`define FSIL_THR_3M 12'd5
`define FSIL_THR_6M 12'd2

`endif

/* fsil_uart.v */
// fsil_uart.v: fixed-format asynchronous serial transmitter and receiver
// assumes rx_in is synchronous to clk_in and rst_n_in is an already synchronised reset
`include "fsil_defines.vh"
`default_nettype none

module fsil_uart #(
  parameter BIT_CYC = `FSIL_UART_BIT_CYC
) (
  input wire clk_in, // system clock
  input wire rst_n_in, // synchronised reset, active low
  input wire [7:0] tx_data_in, // byte to send
  input wire tx_valid_in, // byte offered
  output wire tx_ready_out, // transmitter idle
  output reg tx_out, // serial line out, idle high
  input wire rx_in, // serial line in
  output reg [7:0] rx_data_out, // last byte received
  output reg rx_valid_out, // one-cycle pulse, good byte
  output reg rx_frame_err_out // one-cycle pulse, bad stop bit
);

// counters are 12 bits wide, so the bit time is cut to that width on purpose
localparam [11:0] BIT_LAST = BIT_CYC[11:0] - 12'h001;
localparam [11:0] BIT_HALF = BIT_CYC[11:0] >> 1;

////////////////////////////////////////////////////////////////////////////////
reg tx_busy_r;
reg [9:0] tx_shift_r;
reg [3:0] tx_bits_r;
reg [11:0] tx_cyc_r;

assign tx_ready_out = ~tx_busy_r;

// frame: start, eight data lsb first, stop; no parity slot
always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    tx_busy_r <= 1'b0;
    tx_shift_r <= 10'h3FF;
    tx_bits_r <= 4'h0;
    tx_cyc_r <= 12'h000;
    tx_out <= 1'b1;
  end else if (!tx_busy_r) begin
    tx_out <= 1'b1;
    if (tx_valid_in) begin
      tx_busy_r <= 1'b1; // see [RULE_11]
      tx_shift_r <= {1'b1, tx_data_in, 1'b0};
      tx_bits_r <= 4'h0;
      tx_cyc_r <= 12'h000;
    end
  end else begin
    tx_out <= tx_shift_r[0];
    if (tx_cyc_r == BIT_LAST) begin
      tx_cyc_r <= 12'h000;
      tx_shift_r <= {1'b1, tx_shift_r[9:1]};
      if (tx_bits_r == 4'h9) begin
        tx_busy_r <= 1'b0;
      end
      tx_bits_r <= tx_bits_r + 4'h1;
    end else begin
      tx_cyc_r <= tx_cyc_r + 12'h001;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
reg rx_busy_r;
reg rx_prev_r;
reg [3:0] rx_bits_r;
reg [11:0] rx_cyc_r;
reg [7:0] rx_shift_r;

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    rx_busy_r <= 1'b0;
    rx_prev_r <= 1'b1;
    rx_bits_r <= 4'h0;
    rx_cyc_r <= 12'h000;
    rx_shift_r <= 8'h00;
    rx_data_out <= 8'h00;
    rx_valid_out <= 1'b0;
    rx_frame_err_out <= 1'b0;
  end else begin
    rx_prev_r <= rx_in;
    rx_valid_out <= 1'b0;
    rx_frame_err_out <= 1'b0;
    if (!rx_busy_r) begin
      if (rx_prev_r && !rx_in) begin
        rx_busy_r <= 1'b1;
        rx_bits_r <= 4'h0;
        rx_cyc_r <= BIT_HALF; // first sample lands mid start bit
      end
    end else if (rx_cyc_r == BIT_LAST) begin
      rx_cyc_r <= 12'h000;
      rx_bits_r <= rx_bits_r + 4'h1;
      if (rx_bits_r == 4'h0) begin
        if (rx_in) begin
          rx_busy_r <= 1'b0; // glitch, not a start bit
        end
      end else if (rx_bits_r <= `FSIL_UART_DATA_BITS) begin
        rx_shift_r <= {rx_in, rx_shift_r[7:1]};
      end else begin
        rx_busy_r <= 1'b0; // see [RULE_11]
        rx_data_out <= rx_shift_r;
        rx_valid_out <= rx_in;
        rx_frame_err_out <= ~rx_in;
      end
    end else begin
      rx_cyc_r <= rx_cyc_r + 12'h001;
    end
  end
end

endmodule
`default_nettype wire

/* fsil_status_checker.sv */
// fsil_status_checker.sv: port-level assertions for the status indicator top
// assumes one clock; the top only samples its inputs from the third edge after reset release
`default_nettype none
module fsil_status_checker (
  input wire logic clk_sys_in, // clock
  input wire logic arst_n_in, // reset, active low
  input wire logic mode_count_in, // count mode
  input wire logic meas_stable_in, // stable
  input wire logic signed [31:0] weight_in, // weight
  input wire logic [31:0] division_in, // division
  input wire logic conv_err_in, // conversion error
  input wire logic proc_err_in, // processing error
  input wire logic [1:0] err_type_in, // error type
  input wire logic stable_led_out, // stable led
  input wire logic zero_led_out, // zero led
  input wire logic error_led_out, // error led
  input wire logic fb_init_done_in, // module ready
  input wire logic fb_diag_in, // diagnostics
  input wire logic fb_exception_in, // exception
  input wire logic module_state_led_green_out, // green
  input wire logic module_state_led_red_out, // red
  input wire logic [6:0] addr_switch_in, // switch address
  input wire logic addr_switch_load_in, // switch load
  input wire logic [6:0] slave_addr_out, // address
  input wire logic addr_reject_out, // refused
  input wire logic aux_tx_valid_in, // aux offer
  input wire logic aux_tx_ready_out, // aux idle
  input wire logic aux_tx_out // aux line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] up_r;
  wire logic go = (up_r == 3'h5);
  wire logic err = conv_err_in | proc_err_in;
  wire logic wf = !mode_count_in && !err;
  wire logic [31:0] mag = weight_in[31] ? (32'h0 - weight_in) : weight_in;
  // widened so the most negative weight cannot wrap into the zero band
  wire logic near0 = ({mag, 2'h0} < {2'h0, division_in});
  wire logic sg = module_state_led_green_out;
  wire logic sr = module_state_led_red_out;
  wire logic bad_sw = (addr_switch_in == 7'h00) || (addr_switch_in == 7'h7F);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////
  // outputs still show reset for a few edges after release, so checks wait here
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) up_r <= 3'h0;
    else if (up_r != 3'h5) up_r <= up_r + 3'h1;
  end
  err_led_a: assert property (go |-> error_led_out == $past(err))
    else $error("error led wrong");
  err_code_a: assert property (go && error_led_out |-> {zero_led_out, stable_led_out} == $past(err_type_in))
    else $error("error code leds wrong");
  zero_count_a: assert property (go && $past(mode_count_in && !err) |-> !zero_led_out)
    else $error("zero led lit in count mode");
  stable_wf_a: assert property (go && $past(wf) |-> stable_led_out == $past(meas_stable_in))
    else $error("stable led wrong");
  zero_band_a: assert property (go && $past(wf) |-> zero_led_out == $past(near0))
    else $error("zero led wrong");
  state_red_a: assert property (go && $past(fb_init_done_in && fb_exception_in) |-> sr && !sg)
    else $error("state led not red");
  state_green_a: assert property (go && $past(fb_init_done_in && !fb_exception_in && !fb_diag_in) |-> sg && !sr)
    else $error("state led not green");
  addr_refuse_a: assert property (go && addr_switch_load_in && bad_sw |=> addr_reject_out && $stable(slave_addr_out))
    else $error("bad address taken");
  addr_take_a: assert property (go && addr_switch_load_in && !bad_sw |=> slave_addr_out == $past(addr_switch_in))
    else $error("switch address not taken");
  tx_start_a: assert property (go && aux_tx_valid_in && aux_tx_ready_out |=> !aux_tx_ready_out ##2 !aux_tx_out [*8])
    else $error("no start bit");
endmodule
bind fsil_status_top fsil_status_checker u_chk (.clk_sys_in, .arst_n_in, .mode_count_in, .meas_stable_in,
  .weight_in, .division_in, .conv_err_in, .proc_err_in, .err_type_in, .stable_led_out, .zero_led_out,
  .error_led_out, .fb_init_done_in, .fb_diag_in, .fb_exception_in, .module_state_led_green_out,
  .module_state_led_red_out, .addr_switch_in, .addr_switch_load_in, .slave_addr_out, .addr_reject_out,
  .aux_tx_valid_in, .aux_tx_ready_out, .aux_tx_out);
`default_nettype wire

/* fsil_fb_master.sv */
// fsil_fb_master.sv: far-side model, a fieldbus line toggler and an echoing aux host
// assumes the bench sets run_cyc_in before raising run_en_in
`default_nettype none
module fsil_fb_master (
  input wire logic clk_in, // clock
  input wire logic run_en_in, // toggle the line
  input wire logic [11:0] run_cyc_in, // clocks per bit
  output var logic fb_line_out, // fieldbus line
  input wire logic aux_from_dut_in, // aux from device
  output wire logic aux_to_dut_out // aux to device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cnt_r = 12'h000;
  initial fb_line_out = 1'b1;
  ////////////////////////////////////////
  // line rests where it stopped; only edge spacing matters to rate detection
  always @(posedge clk_in) begin
    if (!run_en_in) cnt_r <= 12'h000;
    else if (cnt_r == run_cyc_in - 12'h001) begin
      cnt_r <= 12'h000;
      fb_line_out <= ~fb_line_out;
    end else cnt_r <= cnt_r + 12'h001;
  end
  // host echoes each character at once in the same framing
  assign aux_to_dut_out = aux_from_dut_in;
endmodule
`default_nettype wire

/* fieldbus_status_indicator_logic_tb_top.sv */
// fieldbus_status_indicator_logic_tb_top.sv: self-checking bench for the status indicator top
// assumes TICK_CYC of 4, so each millisecond of a led pattern lasts four clocks
`default_nettype none
`define FSIL_CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module fieldbus_status_indicator_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  typedef struct packed {
    logic [1:0] ms;
    logic signed [31:0] w;
    logic [3:0] er;
    logic [4:0] fb;
    logic [6:0] exp;
  } fsil_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg = 1'b0;
  logic rrs = 1'b0;
  logic txv = 1'b0;
  logic ren = 1'b0;
  logic [7:0] txd = 8'h00;
  logic [11:0] rc = 12'h823;
  logic [15:0] ad = 16'h0000;
  fsil_row_t cur = '0;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, n2, n3;
  wire logic sl, zl, el, mg, mr, og, orr, lk, txr, txo, rxi, fbl, rxv, rxe, rej;
  wire logic [3:0] rate;
  wire logic [6:0] sa;
  wire logic [7:0] rxd;
  wire logic [6:0] leds = {sl, zl, el, mg, mr, og, orr};
  wire logic [3:0] mon = {sl, mg, og, orr};
  // mode/stable, weight, errors and type, init/diag/exception/online/exchange, leds; division is 100
  fsil_row_t rows [0:6] = '{{2'h1, 32'h18, 4'h0, 5'h13, 7'h6A}, {2'h0, 32'hFFFFFFE8, 4'h0, 5'h00, 7'h20},
    {2'h1, 32'h19, 4'h0, 5'h17, 7'h46}, {2'h0, 32'hFFFFFFE7, 4'h0, 5'h1F, 7'h06},
    {2'h1, 32'h0, 4'hA, 5'h13, 7'h3A}, {2'h2, 32'h0, 4'h5, 5'h13, 7'h5A}, {2'h1, 32'h80000000, 4'h0, 5'h13, 7'h4A}};
  logic [23:0] at [0:4] = '{{16'hFE00, 8'hFC}, {16'hFF00, 8'hFD}, {16'h0080, 8'hFD}, {16'h8589, 8'h0A}, {16'h0081, 8'h02}};
  logic [15:0] rt [0:1] = '{{12'h823, 4'h0}, {12'h028, 4'h5}};
  fsil_status_top #(.TICK_CYC(TK)) dut (
    .clk_sys_in(clk), .arst_n_in(rst_n), .mode_count_in(cur.ms[1]), .meas_stable_in(cur.ms[0]),
    .weight_in(cur.w), .division_in(32'h00000064), .conv_err_in(cur.er[3]), .proc_err_in(cur.er[2]),
    .err_type_in(cur.er[1:0]), .stable_led_out(sl), .zero_led_out(zl), .error_led_out(el),
    .fb_init_done_in(cur.fb[4]), .fb_diag_in(cur.fb[3]), .fb_exception_in(cur.fb[2]),
    .module_state_led_green_out(mg), .module_state_led_red_out(mr), .fb_online_in(cur.fb[1]),
    .fb_data_exch_in(cur.fb[0]), .fb_cfg_err_in(cfg), .link_operation_led_green_out(og),
    .link_operation_led_red_out(orr), .fb_rx_in(fbl), .fb_rate_restart_in(rrs), .fb_rate_out(rate),
    .fb_rate_lock_out(lk), .addr_switch_in(ad[14:8]), .addr_switch_load_in(ad[15]), .addr_cfg_in(ad[6:0]),
    .addr_cfg_load_in(ad[7]), .slave_addr_out(sa), .addr_reject_out(rej), .aux_tx_data_in(txd),
    .aux_tx_valid_in(txv), .aux_tx_ready_out(txr), .aux_tx_out(txo), .aux_rx_in(rxi),
    .aux_rx_data_out(rxd), .aux_rx_valid_out(rxv), .aux_rx_frame_err_out(rxe));
  fsil_fb_master far (.clk_in(clk), .run_en_in(ren), .run_cyc_in(rc), .fb_line_out(fbl),
    .aux_from_dut_in(txo), .aux_to_dut_out(rxi));
  ////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // waits for level v on a pattern led, then counts how long it stays
  task automatic run_len(input int k, input logic v, output int c);
    c = 0;
    while (mon[k] !== v && c < 20000) begin
      @(negedge clk);
      c++;
    end
    c = 0;
    while (mon[k] === v && c < 20000) begin
      @(negedge clk);
      c++;
    end
    @(posedge clk);
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    `FSIL_CHK({leds, rate, lk, sa, txo, txr}, {7'h00, 4'hF, 1'b0, 7'h01, 2'h3})
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      cur <= rows[i];
      repeat (3) @(posedge clk);
      @(negedge clk);
      `FSIL_CHK(leds, rows[i].exp)
      @(posedge clk);
    end
    $display("table test done");
    // first low may be cut short by the mode change, so it is thrown away
    cur <= {2'h2, 32'h0, 4'h0, 5'h13, 7'h00};
    run_len(3, 1'b0, n);
    run_len(3, 1'b1, n2);
    run_len(3, 1'b0, n);
    `FSIL_CHK(n, 300 * TK)
    `FSIL_CHK(n2, 1700 * TK)
    `FSIL_CHK(zl, 1'b0)
    cur.fb[3] <= 1'b1;
    run_len(2, 1'b0, n);
    run_len(2, 1'b1, n);
    `FSIL_CHK(n, 500 * TK)
    cur.fb[0] <= 1'b0;
    run_len(1, 1'b0, n);
    run_len(1, 1'b1, n);
    `FSIL_CHK(n, 500 * TK)
    cfg <= 1'b1;
    run_len(0, 1'b1, n);
    run_len(0, 1'b0, n);
    run_len(0, 1'b1, n2);
    run_len(0, 1'b0, n3);
    `FSIL_CHK({og, n2, n + n3}, {1'b0, 200 * TK, 1600 * TK})
    $display("pattern test done");
    for (int i = 0; i < 5; i++) begin
      ad <= at[i][23:8];
      @(posedge clk);
      ad <= at[i][23:8] & 16'h7F7F;
      @(negedge clk);
      `FSIL_CHK({sa, rej}, at[i][7:0])
      @(posedge clk);
    end
    $display("address test done");
    for (int i = 0; i < 2; i++) begin
      rrs <= 1'b1;
      @(posedge clk);
      rrs <= 1'b0;
      rc <= rt[i][15:4];
      ren <= 1'b1;
      @(negedge clk);
      `FSIL_CHK({lk, rate}, 5'h0F)
      repeat (5 * rt[i][15:4]) @(posedge clk);
      ren <= 1'b0;
      @(negedge clk);
      `FSIL_CHK({lk, rate}, {1'b1, rt[i][3:0]})
      @(posedge clk);
    end
    $display("rate test done");
    txd <= 8'hA5;
    txv <= 1'b1;
    @(posedge clk);
    txv <= 1'b0;
    @(negedge clk);
    `FSIL_CHK(txr, 1'b0)
    n = 0;
    while (rxv !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    `FSIL_CHK({rxe, rxd}, 9'h0A5)
    $display("serial test done");
    end_of_test();
  end
endmodule
`default_nettype wire
